// ==== design/schbp_host_port.sv ====
/*
 * Host parallel bus port of a serial controller: strobe handling, byte or
 * pair addressing, control and status registers, handshake outputs, interrupt
 * request and the auxiliary pin.
 * Assumes all bus pins are asynchronous to clock_i and that strobes last well
 * over three clock periods; receiver and transmitter logic sit on clock_i.
 */
// What this block does
// - The auxiliary pin is an input or an output as the direction bit of the receiver control register says.
// - As an input, a low level on the auxiliary pin sets the end-of-message flag of the transmitter control register.
// - As an output, the auxiliary pin follows bit 14 of the receiver control register.
// - The byte pin selects an 8-bit bus when high and a 16-bit bus when low, and the port works in that width.
// - While chip select and read are both low, the addressed register is driven onto the data bus.
// - The data bus value taken while chip select and write are both low is loaded into the addressed register when the write ends.
// - Receive-available is high while a character waits and clears on the rising read edge that reads it.
// - A low reset pin disables transmitter and receiver and initialises the control registers and timing.
// - The interrupt request goes low when an interrupt-linked status condition arises.
// - The linked conditions are receiver overrun, end-of-message with framing error, parity error and underrun.
// - The interrupt is released on the trailing read edge of the last status register still holding a linked condition.
// - On an 8-bit bus the three address pins select one of eight byte registers.
// - On a 16-bit bus the lowest address pin is ignored and the upper two select one of four register pairs.
`timescale 1ns/1ps
module schbp_host_port (
   input  wire logic                  clock_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  reset_n_i,
   input  wire logic                  cs_n_i,
   input  wire logic                  rd_n_i,
   input  wire logic                  wr_n_i,
   input  wire logic                  byte_mode_i,
   input  wire logic [schbp_pkg::AW-1:0] addr_i,
   input  wire logic [schbp_pkg::DW-1:0] data_i,
   output logic      [schbp_pkg::DW-1:0] data_o,
   output logic                       data_oe_n_o,
   input  wire logic                  aux_i,
   output logic                       aux_o,
   output logic                       aux_oe_n_o,
   output logic                       irq_n_o,
   output logic                       receive_available_out_o,
   output logic                       transmit_empty_out_o,
   input  wire logic                  rx_char_load_i,
   input  wire logic [schbp_pkg::DW-1:0] rx_data_i,
   input  wire logic                  rx_overrun_i,
   input  wire logic                  rx_eom_framing_i,
   input  wire logic                  rx_parity_i,
   input  wire logic                  tx_underrun_i,
   input  wire logic                  tx_taken_i,
   output logic      [schbp_pkg::DW-1:0] tx_data_o,
   output logic                       tx_load_o,
   output logic                       tx_enable_o,
   output logic                       rx_enable_o,
   output logic                       end_of_message_flag_o
);
   import schbp_pkg::*;

   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic              rd_act_r;
   logic              wr_act_r;
   logic [AW-1:0]     acc_addr_r;
   logic [DW-1:0]     acc_data_r;
   logic              acc_byte_r;
   logic [DW-1:0]     receiver_control_register_r;
   logic [DW-1:0]     tx_ctl_r;
   logic [DW-1:0]     tx_data_r;
   logic [DW-1:0]     rx_data_r;
   logic [2:0]        rx_st_r;
   logic              tx_und_r;
   logic              rx_avail_r;
   logic              tx_empty_r;
   logic              tx_load_r;
   logic [DW-1:0]     data_out_r;
   logic              data_oe_n_r;
   logic              aux_out_r;
   logic              aux_oe_n_r;
   logic              irq_n_r;

   // Pins first pass two flops; only the second stage is read
   wire              rst_n_s = sync2_r[24];
   wire              cs_n_s  = sync2_r[23];
   wire              rd_n_s  = sync2_r[22];
   wire              wr_n_s  = sync2_r[21];
   wire              byte_s  = sync2_r[20];
   wire              aux_s   = sync2_r[19];
   wire [AW-1:0]     addr_s  = sync2_r[18:16];
   wire [DW-1:0]     data_s  = sync2_r[15:0];

   wire rst = sys_rst_i | ~rst_n_s;
   wire rd_act = ~cs_n_s & ~rd_n_s;
   wire wr_act = ~cs_n_s & ~wr_n_s;
   // Trailing edge: the strobe (or chip select) has gone away
   wire rd_end = rd_act_r & ~rd_act;
   wire wr_end = wr_act_r & ~wr_act;

   // Byte lane selection of the finished access
   wire [1:0] acc_pair = acc_addr_r[2:1];
   wire       lo_en    = ~acc_byte_r | ~acc_addr_r[0];
   wire       hi_en    = ~acc_byte_r | acc_addr_r[0];
   // On a byte bus the high byte arrives on the low lanes
   wire [7:0] hi_dat   = acc_byte_r ? acc_data_r[7:0] : acc_data_r[15:8];
   wire [DW-1:0] wdat  = {hi_dat, acc_data_r[7:0]};

   wire wr_rcr  = wr_end & (acc_pair == PAIR_RXCTL);
   wire wr_tcr  = wr_end & (acc_pair == PAIR_TXCTL);
   wire wr_data = wr_end & (acc_pair == PAIR_DATA);
   wire rd_stat = rd_end & (acc_pair == PAIR_STATUS);
   wire rd_data = rd_end & (acc_pair == PAIR_DATA);

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic lo, input logic hi,
                                           input logic [DW-1:0] d);
      merge = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
   endfunction

   wire aux_is_out = receiver_control_register_r[RCR_AUX_DIR];
   wire eom_set    = ~aux_is_out & ~aux_s;

   wire [DW-1:0] rcr_nxt = wr_rcr ? merge(receiver_control_register_r, lo_en, hi_en, wdat)
                                  : receiver_control_register_r;
   wire [DW-1:0] tcr_wr  = wr_tcr ? merge(tx_ctl_r, lo_en, hi_en, wdat) : tx_ctl_r;
   // Pin level wins over a write that clears the flag
   wire [DW-1:0] tcr_nxt = tcr_wr | (DW'(eom_set) << TCR_EOM);
   wire          tx_wr_lo = wr_data & lo_en;
   wire [DW-1:0] txd_nxt = wr_data ? merge(tx_data_r, lo_en, hi_en, wdat) : tx_data_r;

   // Sticky status; a new event in the clearing cycle survives
   wire [2:0] rx_set    = {rx_parity_i, rx_eom_framing_i, rx_overrun_i};
   wire       clr_rx    = rd_stat & lo_en;
   wire       clr_tx    = rd_stat & hi_en;
   wire [2:0] rx_st_nxt = (rx_st_r & ~{3{clr_rx}}) | rx_set;
   wire       tx_und_nxt = (tx_und_r & ~clr_tx) | tx_underrun_i;
   wire       irq_nxt_n = ~(|rx_st_nxt | tx_und_nxt);

   wire rx_avail_nxt = rx_char_load_i | (rx_avail_r & ~(rd_data & lo_en));
   wire tx_empty_nxt = tx_taken_i | (tx_empty_r & ~tx_wr_lo);

   // Read view of the four pairs
   wire [DW-1:0] stat_word = {6'h00, tx_empty_r, tx_und_r, 4'h0, rx_avail_r, rx_st_r};
   wire [DW-1:0] rd_word = (addr_s[2:1] == PAIR_STATUS) ? stat_word :
                           (addr_s[2:1] == PAIR_RXCTL)  ? receiver_control_register_r :
                           (addr_s[2:1] == PAIR_TXCTL)  ? tx_ctl_r : rx_data_r;
   wire [7:0]    rd_byte = addr_s[0] ? rd_word[15:8] : rd_word[7:0];
   // Byte mode shows the byte on both halves since they are tied together
   wire [DW-1:0] rd_out  = byte_s ? {rd_byte, rd_byte} : rd_word;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else begin
         sync1_r <= {reset_n_i, cs_n_i, rd_n_i, wr_n_i, byte_mode_i, aux_i, addr_i, data_i};
         sync2_r <= sync1_r;
      end
   end

   // Address and data are captured while the strobe is low, used at its end
   always_ff @(posedge clock_i) begin
      if (rst) begin
         rd_act_r   <= 1'b0;
         wr_act_r   <= 1'b0;
         acc_addr_r <= '0;
         acc_data_r <= DATA_RST;
         acc_byte_r <= 1'b1;
      end else begin
         rd_act_r <= rd_act;
         wr_act_r <= wr_act;
         if (rd_act | wr_act) begin
            acc_addr_r <= addr_s;
            acc_data_r <= data_s;
            acc_byte_r <= byte_s;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst) begin
         receiver_control_register_r <= RCR_RST;
         tx_ctl_r   <= TCR_RST;
         tx_data_r  <= DATA_RST;
         tx_load_r  <= 1'b0;
         rx_data_r  <= DATA_RST;
         rx_st_r    <= RXST_RST;
         tx_und_r   <= 1'b0;
         rx_avail_r <= 1'b0;
         tx_empty_r <= 1'b1;
         irq_n_r    <= 1'b1;
      end else begin
         receiver_control_register_r <= rcr_nxt;
         tx_ctl_r   <= tcr_nxt;
         tx_data_r  <= txd_nxt;
         tx_load_r  <= tx_wr_lo;
         if (rx_char_load_i) begin
            rx_data_r <= rx_data_i;
         end
         rx_st_r    <= rx_st_nxt;
         tx_und_r   <= tx_und_nxt;
         rx_avail_r <= rx_avail_nxt;
         tx_empty_r <= tx_empty_nxt;
         irq_n_r    <= irq_nxt_n;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst) begin
         data_out_r  <= DATA_RST;
         data_oe_n_r <= 1'b1;
         aux_out_r   <= 1'b0;
         aux_oe_n_r  <= 1'b1;
      end else begin
         data_out_r  <= rd_out;
         data_oe_n_r <= ~rd_act;
         aux_out_r   <= rcr_nxt[RCR_AUX_OUT];
         aux_oe_n_r  <= ~rcr_nxt[RCR_AUX_DIR];
      end
   end

   assign data_o                  = data_out_r;
   assign data_oe_n_o             = data_oe_n_r;
   assign aux_o                   = aux_out_r;
   assign aux_oe_n_o              = aux_oe_n_r;
   assign irq_n_o                 = irq_n_r;
   assign receive_available_out_o = rx_avail_r;
   assign transmit_empty_out_o    = tx_empty_r;
   assign tx_data_o               = tx_data_r;
   assign tx_load_o               = tx_load_r;
   assign tx_enable_o             = tx_ctl_r[TCR_TX_EN];
   assign rx_enable_o             = receiver_control_register_r[RCR_RX_EN];
   assign end_of_message_flag_o   = tx_ctl_r[TCR_EOM];
endmodule // schbp_host_port

// ==== design/schbp_pkg.sv ====
/*
 * Constants for the host bus port of the serial controller: register pairs,
 * bit positions and reset values.
 * Assumes nothing of its surroundings.
 */
package schbp_pkg;
   localparam int DW = 16;
   localparam int AW = 3;
   localparam int SYNC_W = 25;

   // Register pair index, taken from address bits 2:1
   localparam logic [1:0] PAIR_STATUS = 2'h0;
   localparam logic [1:0] PAIR_RXCTL  = 2'h1;
   localparam logic [1:0] PAIR_TXCTL  = 2'h2;
   localparam logic [1:0] PAIR_DATA   = 2'h3;

   // Status pair: receiver bits in the low byte, transmitter bits in the high byte
   localparam int ST_RX_OVERRUN  = 0;
   localparam int ST_RX_EOM_FRM  = 1;
   localparam int ST_RX_PARITY   = 2;
   localparam int ST_RX_AVAIL    = 3;
   localparam int ST_TX_UNDERRUN = 8;
   localparam int ST_TX_EMPTY    = 9;

   // Receiver control register
   localparam int RCR_RX_EN   = 0;
   localparam int RCR_AUX_DIR = 13;
   localparam int RCR_AUX_OUT = 14;

   // Transmitter control register
   localparam int TCR_TX_EN = 0;
   localparam int TCR_EOM   = 9;

   localparam logic [15:0] RCR_RST   = 16'h0000;
   localparam logic [15:0] TCR_RST   = 16'h0000;
   localparam logic [15:0] DATA_RST  = 16'h0000;
   localparam logic [2:0]  RXST_RST  = 3'h0;
   localparam logic [24:0] SYNC_RST  = 25'h1FFFFFF;
endpackage

// ==== verif/schbp_host_model.sv ====
/* Host processor model: strobed reads and writes on the parallel bus.
   Assumes the bench resolves the shared data wire from the port's data_oe_n_o alone. */
`timescale 1ns/1ps
module schbp_host_model (
   input  wire logic        clock_i,
   input  wire logic        byte_mode_i,
   input  wire logic [15:0] bus_i,
   output logic             cs_n_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic [2:0]       addr_o,
   output logic [15:0]      data_o
);
   initial begin
      {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
      addr_o = 3'h0;
      data_o = 16'h0000;
   end
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(negedge clock_i);
      addr_o = a;
      data_o = byte_mode_i ? {2{d[7:0]}} : d;
      {cs_n_o, wr_n_o} = 2'h0;
      repeat (5) @(negedge clock_i);
      {cs_n_o, wr_n_o} = 2'h3;
      // No pull-up: a released bus must not keep the old value
      data_o = ~data_o;
      repeat (5) @(negedge clock_i);
   endtask
   task rd(input logic [2:0] a, output logic [15:0] q);
      @(negedge clock_i);
      addr_o = a;
      {cs_n_o, rd_n_o} = 2'h0;
      // Data has stood since the third edge; taken off the edge, then released
      repeat (5) @(negedge clock_i);
      q = bus_i;
      {cs_n_o, rd_n_o} = 2'h3;
      repeat (5) @(negedge clock_i);
   endtask
endmodule // schbp_host_model

// ==== verif/schbp_host_port_chk.sv ====
/* Pin-level assertions for the host port.
   Assumes it is bound into every schbp_host_port instance. */
`timescale 1ns/1ps
module schbp_host_port_chk (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic reset_n_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic rx_char_load_i,
   input wire logic rx_overrun_i,
   input wire logic rx_eom_framing_i,
   input wire logic rx_parity_i,
   input wire logic tx_underrun_i,
   input wire logic tx_taken_i,
   input wire logic data_oe_n_o,
   input wire logic irq_n_o,
   input wire logic receive_available_out_o,
   input wire logic transmit_empty_out_o
);
   wire logic ev = rx_overrun_i | rx_eom_framing_i | rx_parity_i | tx_underrun_i;
   default clocking @(posedge clock_i); endclocking
   // Pin reset takes two edges to land, so both resets mask checking
   default disable iff (sys_rst_i || !reset_n_i);
   sequence rd_held; (!cs_n_i && !rd_n_i) [*4]; endsequence
   sequence bus_idle; cs_n_i [*4]; endsequence
   irq_set_a: assert property (ev |=> !irq_n_o) else $error("irq not raised");
   irq_hold_a: assert property ((!irq_n_o && rd_n_i) [*6] |=> !irq_n_o) else $error("irq lost");
   rda_set_a: assert property (rx_char_load_i |=> receive_available_out_o) else $error("rx flag not set");
   rda_hold_a: assert property ((receive_available_out_o && rd_n_i) [*6] |=> receive_available_out_o)
      else $error("rx flag lost");
   transmit_empty_out_set_a: assert property (tx_taken_i |=> transmit_empty_out_o) else $error("tx flag not set");
   transmit_empty_out_hold_a: assert property ((!transmit_empty_out_o && !tx_taken_i) [*2] |=> !transmit_empty_out_o)
      else $error("tx flag set early");
   read_drive_a: assert property (rd_held |=> !data_oe_n_o) else $error("read not driven");
   idle_rel_a: assert property (bus_idle |=> data_oe_n_o) else $error("bus not released");
endmodule // schbp_host_port_chk
bind schbp_host_port schbp_host_port_chk schbp_host_port_chk_inst (.*);

// ==== verif/schbp_host_port_test.sv ====
/* Self-checking bench of the host port: bus accesses via the host model,
   event pulses from a stand-in serial core. Assumes the bound checker. */
`timescale 1ns/1ps
module schbp_host_port_test;
   import schbp_pkg::*;
   logic        clock_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        reset_n_i = 1'b1;
   logic        byte_mode_i = 1'b0;
   logic        aux_ext = 1'b1;
   logic [5:0]  pl = 6'h00;
   logic [15:0] rx_data_i = 16'h0000;
   logic [15:0] host_d, data_o, tx_data_o, q;
   logic [2:0]  addr_i;
   logic        cs_n_i, rd_n_i, wr_n_i, data_oe_n_o, aux_o, aux_oe_n_o, irq_n_o, tx_load_o;
   logic        receive_available_out_o, transmit_empty_out_o, tx_enable_o, rx_enable_o, end_of_message_flag_o;
   int          fail_count = 0;
   int          comparisons = 0;
   int          tx_loads = 0;
   wire logic [15:0] data_i = data_oe_n_o ? host_d : data_o;
   wire logic        aux_i = aux_oe_n_o ? aux_ext : aux_o;
   always #2.5 clock_i = ~clock_i;
   // One-cycle pulse, counted off the edge that launches it
   always @(negedge clock_i) tx_loads += int'(tx_load_o);
   schbp_host_port schbp_host_port_inst (.*, .rx_char_load_i(pl[4]), .rx_overrun_i(pl[0]),
      .rx_eom_framing_i(pl[1]), .rx_parity_i(pl[2]), .tx_underrun_i(pl[3]), .tx_taken_i(pl[5]));
   schbp_host_model schbp_host_model_inst (.clock_i(clock_i), .byte_mode_i(byte_mode_i), .bus_i(data_i),
      .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .addr_o(addr_i), .data_o(host_d));
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      schbp_host_model_inst.wr(a, d);
   endtask
   task rd(input logic [2:0] a);
      schbp_host_model_inst.rd(a, q);
   endtask
   task pulse(input int i);
      @(negedge clock_i);
      pl[i] = 1'b1;
      @(negedge clock_i);
      pl[i] = 1'b0;
   endtask
   task end_of_test;
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      end_of_test;
   end
   initial begin
      repeat (8) @(negedge clock_i);
      sys_rst_i = 1'b0;
      @(negedge clock_i);
      chk("rst", 16'h0031, 16'({irq_n_o, transmit_empty_out_o, receive_available_out_o,
         rx_enable_o, tx_enable_o, data_oe_n_o}));
      wr(3'h3, 16'h6001);
      chk("rcr", 16'h0005, 16'({rx_enable_o, aux_oe_n_o, aux_o}));
      rd(3'h2);
      chk("rcr_rd", 16'h6001, q);
      wr(3'h2, 16'h0001);
      chk("aux_in", 16'h0002, 16'({aux_oe_n_o, end_of_message_flag_o}));
      aux_ext = 1'b0;
      repeat (5) @(negedge clock_i);
      chk("eom", 16'h0001, 16'(end_of_message_flag_o));
      aux_ext = 1'b1;
      wr(3'h6, 16'hA55A);
      chk("tx", 16'hA55A, tx_data_o);
      chk("tx_load", 16'h0001, 16'(tx_loads));
      chk("transmit_empty_out_clr", 16'h0000, 16'(transmit_empty_out_o));
      pulse(5);
      chk("transmit_empty_out_set", 16'h0001, 16'(transmit_empty_out_o));
      rx_data_i = 16'h1234;
      pulse(4);
      // Idle long enough for the hold check to see the flag stand
      repeat (6) @(negedge clock_i);
      chk("rda_set", 16'h0001, 16'(receive_available_out_o));
      rd(3'h6);
      chk("rx", 16'h1234, q);
      chk("rda_clr", 16'h0000, 16'(receive_available_out_o));
      for (int i = 0; i < 4; i++) begin
         pulse(i);
         chk("irq_ev", 16'h0000, 16'(irq_n_o));
         rd(3'h0);
         chk("st_bit", 16'h0001, 16'(q[(i < 3) ? i : 8]));
         chk("irq_rel", 16'h0001, 16'(irq_n_o));
      end
      byte_mode_i = 1'b1;
      pulse(0);
      pulse(3);
      rd(3'h0);
      chk("irq_held", 16'h0000, 16'(irq_n_o));
      rd(3'h1);
      // Underrun still pending when read, so bit 0 of the high byte is set
      chk("st_hi", 16'h0003, 16'({q[0], irq_n_o}));
      wr(3'h3, 16'h0060);
      chk("aux8", 16'h0001, 16'(aux_o));
      rd(3'h3);
      chk("dup", 16'h6060, q);
      rd(3'h2);
      chk("rcr_lo", 16'h0101, q);
      wr(3'h4, 16'h0001);
      chk("tcr8", 16'h0003, 16'({tx_enable_o, end_of_message_flag_o}));
      reset_n_i = 1'b0;
      repeat (4) @(negedge clock_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clock_i);
      chk("pin_rst", 16'h0003, 16'({rx_enable_o, tx_enable_o, end_of_message_flag_o, aux_o, aux_oe_n_o,
         transmit_empty_out_o}));
      end_of_test;
   end
endmodule // schbp_host_port_test
